// >>> verilog/cxp_cfg.svh
// Constants for the configuration extend port: windows, field widths, clock rates and reset values
`ifndef CXP_CFG_SVH
`define CXP_CFG_SVH

// Register number windows served by user logic
`define CXP_LEGACY_LO 10'h010
`define CXP_LEGACY_HI 10'h01f
`define CXP_EXTENDED_LO 10'h100
`define CXP_EXTENDED_HI 10'h3ff

// Field widths
`define CXP_REG_W 10
`define CXP_FUNC_W 8
`define CXP_DATA_W 32
`define CXP_BE_W 4

// Clock rates in kHz; the user tick is derived from the system clock
`define CXP_SYS_CLK_KHZ 200000
`define CXP_UCLK_LO_KHZ 62500
`define CXP_UCLK_MID_KHZ 125000
`define CXP_UCLK_HI_KHZ 250000
`define CXP_ACC_W 16

// Reset values
`define CXP_RST_DATA 32'h0000_0000

`endif

// >>> verilog/cxp_pkg.sv
// Types shared by the configuration extend port modules
`default_nettype none
package cxp_pkg;
	typedef enum logic [1:0] {CXP_RATE_LO, CXP_RATE_MID, CXP_RATE_HI} cxp_rate_t;
	typedef enum logic {CXP_IDLE, CXP_READ} cxp_state_t;
endpackage
`default_nettype wire

// >>> verilog/cxp_clk_if.sv
// Carrier between the request engine and the user clock and reset generator
`timescale 1ns/100ps
`default_nettype none
interface cxp_clk_if;
	logic fund_rst;
	cxp_pkg::cxp_rate_t rate_sel;
	logic user_reset;
	logic user_tick;
	modport gen (input fund_rst, input rate_sel, output user_reset, output user_tick);
	modport use_side (output fund_rst, output rate_sel, input user_reset, input user_tick);
endinterface
`default_nettype wire

// >>> verilog/cxp_clk_rst.sv
// User reset synchroniser and user clock-rate tick generator
`include "cxp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module cxp_clk_rst (
	input wire logic clk,
	input wire logic srst,
	cxp_clk_if.gen crif
);
	localparam longint INC_LO = (longint'(`CXP_UCLK_LO_KHZ) << `CXP_ACC_W) / `CXP_SYS_CLK_KHZ;
	localparam longint INC_MID = (longint'(`CXP_UCLK_MID_KHZ) << `CXP_ACC_W) / `CXP_SYS_CLK_KHZ;
	localparam logic [`CXP_ACC_W:0] ACC_MAX = {1'b0, {`CXP_ACC_W{1'b1}}};

	logic sync1_reg;
	logic sync2_reg;
	logic [`CXP_ACC_W-1:0] acc_reg;
	logic tick_reg;
	logic [`CXP_ACC_W:0] inc;
	logic [`CXP_ACC_W:0] sum;

	// Asserts at once on fundamental reset, releases two clocks later on our edge
	always_ff @(posedge clk or posedge crif.fund_rst)
	begin
		if (crif.fund_rst)
		begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end
		else
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= sync1_reg;
		end
	end

	// Phase step per rate; the top rate exceeds the system clock, so it ticks every cycle
	assign inc = (crif.rate_sel == cxp_pkg::CXP_RATE_LO) ? (`CXP_ACC_W+1)'(INC_LO) :
		(crif.rate_sel == cxp_pkg::CXP_RATE_MID) ? (`CXP_ACC_W+1)'(INC_MID) : ACC_MAX + 1'b1;
	assign sum = {1'b0, acc_reg} + inc;

	// Carry out of the accumulator marks one user clock period
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			acc_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			acc_reg <= sum[`CXP_ACC_W-1:0];
			tick_reg <= sum[`CXP_ACC_W];
		end
	end

	assign crif.user_reset = sync2_reg;
	assign crif.user_tick = tick_reg;

	property p_urst_async;
		@(posedge clk) crif.fund_rst |-> crif.user_reset;
	endproperty
	a_urst_async: assert property (p_urst_async)
		else $error("User reset not held during fundamental reset");

	property p_tick_lo;
		@(posedge clk) disable iff (srst)
		(crif.rate_sel == cxp_pkg::CXP_RATE_LO && crif.user_tick) |=> !crif.user_tick ##1 !crif.user_tick;
	endproperty
	a_tick_lo: assert property (p_tick_lo)
		else $error("Low rate tick too frequent");
endmodule
`default_nettype wire

// >>> verilog/cxp_ext_port.sv
// Configuration extend port: forwards link configuration requests to user logic
// Behaviour
// - With no user space enabled every configuration read pulses read-received for one cycle.
// - With legacy user space on, a read of registers 0x10..0x1f holds read-received until valid data.
// - With extended user space on, a read of registers 0x100..0x3ff holds read-received until valid data.
// - A read outside both windows always pulses read-received for exactly one cycle.
// - Each configuration write pulses write-received for one cycle.
// - The 10-bit register number is valid whenever read-received or write-received is high.
// - The 8-bit function number is valid whenever read-received or write-received is high.
// - The 32-bit write data is valid while write-received is high.
// - A 4-bit byte enable qualifies the bytes of each write.
// - Read data is captured on the edge after read-received when its valid strobe is set.
// - User logic raises read-data-valid with the data, sampled on the edge after read-received.
// - A user clock tick for 62.5 or 125 MHz, fixed by configuration, is made from the system clock that times this port; at 250 MHz it ticks every cycle.
// - User reset asserts asynchronously with fundamental reset and releases on the clock.
`include "cxp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module cxp_ext_port (
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic FUND_RST,
	input wire logic [1:0] UCLK_RATE_SEL,
	input wire logic LEGACY_SPACE_EN,
	input wire logic EXTENDED_SPACE_EN,
	input wire logic LINK_REQ_VALID,
	input wire logic LINK_REQ_WRITE,
	input wire logic [`CXP_REG_W-1:0] LINK_REG_NUM,
	input wire logic [`CXP_FUNC_W-1:0] LINK_FUNC_NUM,
	input wire logic [`CXP_DATA_W-1:0] LINK_WR_DATA,
	input wire logic [`CXP_BE_W-1:0] LINK_BYTE_EN,
	output logic LINK_REQ_READY,
	output logic LINK_CPL_VALID,
	output logic LINK_CPL_FROM_USER,
	output logic [`CXP_DATA_W-1:0] LINK_CPL_DATA,
	output logic READ_RECEIVED,
	output logic WRITE_RECEIVED,
	output logic [`CXP_REG_W-1:0] REGISTER_NUMBER,
	output logic [`CXP_FUNC_W-1:0] FUNCTION_NUMBER,
	output logic [`CXP_DATA_W-1:0] WRITE_DATA,
	output logic [`CXP_BE_W-1:0] WRITE_BYTE_ENABLE,
	input wire logic [`CXP_DATA_W-1:0] READ_DATA,
	input wire logic READ_DATA_VALID,
	output logic USER_RESET,
	output logic USER_CLK_TICK
);
	cxp_pkg::cxp_state_t state_reg;
	cxp_pkg::cxp_state_t state_next;
	logic ready_reg;
	logic rd_reg;
	logic wr_reg;
	logic hold_reg;
	logic cpl_valid_reg;
	logic cpl_user_reg;
	logic [`CXP_DATA_W-1:0] cpl_data_reg;
	logic [`CXP_REG_W-1:0] reg_num_reg;
	logic [`CXP_FUNC_W-1:0] func_num_reg;
	logic [`CXP_DATA_W-1:0] wdata_reg;
	logic [`CXP_BE_W-1:0] be_reg;

	cxp_clk_if crif ();

	// Reset and rate tick generation live in their own module
	cxp_clk_rst u_clk_rst (
		.clk(SYS_CLK),
		.srst(SRST),
		.crif(crif)
	);

	assign crif.fund_rst = FUND_RST;
	assign crif.rate_sel = cxp_pkg::cxp_rate_t'(UCLK_RATE_SEL);

	// Request decode: which reads wait for user data
	wire accept = LINK_REQ_VALID && ready_reg;
	wire acc_wr = accept && LINK_REQ_WRITE;
	wire acc_rd = accept && !LINK_REQ_WRITE;
	wire in_legacy = (LINK_REG_NUM >= `CXP_LEGACY_LO) && (LINK_REG_NUM <= `CXP_LEGACY_HI);
	wire in_extended = (LINK_REG_NUM >= `CXP_EXTENDED_LO) && (LINK_REG_NUM <= `CXP_EXTENDED_HI);
	wire hold_legacy = LEGACY_SPACE_EN && in_legacy;
	wire hold_extended = EXTENDED_SPACE_EN && in_extended;
	wire hold_req = hold_legacy || hold_extended;
	wire rd_done_user = (state_reg == cxp_pkg::CXP_READ) && READ_DATA_VALID;
	wire rd_done_self = (state_reg == cxp_pkg::CXP_READ) && !hold_reg;
	wire rd_done = rd_done_user || rd_done_self;

	// Next state: a read parks here until answered or its single pulse is over
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			cxp_pkg::CXP_IDLE:
				if (acc_rd)
					state_next = cxp_pkg::CXP_READ;
			cxp_pkg::CXP_READ:
				if (rd_done)
					state_next = cxp_pkg::CXP_IDLE;
		endcase
	end

	// Control flops; a read stalls the link so the held address stays put
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			state_reg <= cxp_pkg::CXP_IDLE;
			ready_reg <= 1'b0;
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			hold_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			ready_reg <= (state_next == cxp_pkg::CXP_IDLE);
			rd_reg <= (state_next == cxp_pkg::CXP_READ);
			wr_reg <= acc_wr;
			hold_reg <= acc_rd ? hold_req : hold_reg;
		end
	end

	// Request fields are latched at acceptance and held through a pending read
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			reg_num_reg <= '0;
			func_num_reg <= '0;
			wdata_reg <= `CXP_RST_DATA;
			be_reg <= '0;
		end
		else if (accept)
		begin
			reg_num_reg <= LINK_REG_NUM;
			func_num_reg <= LINK_FUNC_NUM;
			wdata_reg <= LINK_WR_DATA;
			be_reg <= LINK_BYTE_EN;
		end
	end

	// Completion back to the link; user data wins if the strobe came in time
	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			cpl_valid_reg <= 1'b0;
			cpl_user_reg <= 1'b0;
			cpl_data_reg <= `CXP_RST_DATA;
		end
		else
		begin
			cpl_valid_reg <= rd_done;
			if (rd_done)
			begin
				cpl_user_reg <= rd_done_user;
				cpl_data_reg <= rd_done_user ? READ_DATA : `CXP_RST_DATA;
			end
		end
	end

	assign LINK_REQ_READY = ready_reg;
	assign LINK_CPL_VALID = cpl_valid_reg;
	assign LINK_CPL_FROM_USER = cpl_user_reg;
	assign LINK_CPL_DATA = cpl_data_reg;
	assign READ_RECEIVED = rd_reg;
	assign WRITE_RECEIVED = wr_reg;
	assign REGISTER_NUMBER = reg_num_reg;
	assign FUNCTION_NUMBER = func_num_reg;
	assign WRITE_DATA = wdata_reg;
	assign WRITE_BYTE_ENABLE = be_reg;
	assign USER_RESET = crif.user_reset;
	assign USER_CLK_TICK = crif.user_tick;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SRST);

	property p_wr_pulse;
		acc_wr |=> WRITE_RECEIVED && WRITE_DATA == $past(LINK_WR_DATA);
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("Write not pulsed with its data");

	property p_wr_cause;
		WRITE_RECEIVED |-> $past(acc_wr);
	endproperty
	a_wr_cause: assert property (p_wr_cause)
		else $error("Write pulse without a write");

	property p_rd_single;
		(acc_rd && !hold_req) |=> READ_RECEIVED ##1 !READ_RECEIVED;
	endproperty
	a_rd_single: assert property (p_rd_single)
		else $error("Unheld read not a one-cycle pulse");

	property p_rd_hold;
		(READ_RECEIVED && hold_reg && !READ_DATA_VALID) |=> READ_RECEIVED && $stable(REGISTER_NUMBER);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("Held read dropped before valid data");

	property p_rd_release;
		(READ_RECEIVED && READ_DATA_VALID) |=> !READ_RECEIVED;
	endproperty
	a_rd_release: assert property (p_rd_release)
		else $error("Read still pending after valid data");

	property p_capture;
		(READ_RECEIVED && READ_DATA_VALID) |=> LINK_CPL_VALID && LINK_CPL_FROM_USER && LINK_CPL_DATA == $past(READ_DATA);
	endproperty
	a_capture: assert property (p_capture)
		else $error("Read data not captured");

	property p_reg_num;
		accept |=> REGISTER_NUMBER == $past(LINK_REG_NUM) && FUNCTION_NUMBER == $past(LINK_FUNC_NUM);
	endproperty
	a_reg_num: assert property (p_reg_num)
		else $error("Register or function number wrong");

	property p_be;
		acc_wr |=> WRITE_BYTE_ENABLE == $past(LINK_BYTE_EN);
	endproperty
	a_be: assert property (p_be)
		else $error("Byte enable wrong");

	c_wr: cover property (acc_wr ##1 acc_wr);
	c_rd_self: cover property (acc_rd && !hold_req);
	c_rd_legacy: cover property (acc_rd && hold_legacy ##1 !READ_DATA_VALID ##1 READ_DATA_VALID);
	c_rd_ext: cover property (acc_rd && hold_extended ##1 READ_DATA_VALID);
endmodule
`default_nettype wire

// >>> test/cxp_user_model.sv
// Behavioural user logic holding the externally served configuration registers
`timescale 1ns/100ps
`default_nettype none
module cxp_user_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic legacy_en,
	input wire logic ext_en,
	input wire logic [2:0] delay,
	input wire logic rd_rcv,
	input wire logic wr_rcv,
	input wire logic [9:0] reg_num,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] be,
	output logic [31:0] rd_data,
	output logic rd_valid
);
	logic [31:0] mem [0:1023];
	logic [2:0] cnt_reg;
	wire in_win = (legacy_en && reg_num >= 10'h010 && reg_num <= 10'h01f) ||
		(ext_en && reg_num >= 10'h100);
	// Known pattern so unwritten registers still give a checkable value
	initial
	begin
		for (int i = 0; i < 1024; i++)
			mem[i] = {8'h5a, 14'h0, i[9:0]};
	end
	// Answer each pending read once after a chosen delay; idle data toggles, never stale
	always @(posedge clk)
	begin
		rd_valid <= 1'b0;
		rd_data <= ~rd_data;
		if (srst)
		begin
			cnt_reg <= 3'h0;
			rd_data <= 32'h0f0f_0f0f;
		end
		else if (rd_rcv && in_win && !rd_valid)
		begin
			if (cnt_reg == delay)
			begin
				rd_valid <= 1'b1;
				rd_data <= mem[reg_num];
				cnt_reg <= 3'h0;
			end
			else
				cnt_reg <= cnt_reg + 3'h1;
		end
		if (wr_rcv)
			for (int i = 0; i < 4; i++)
				if (be[i])
					mem[reg_num][8*i +: 8] <= wr_data[8*i +: 8];
	end
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the configuration extend port
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk = 1'b0, srst = 1'b1, fund = 1'b0, req_v = 1'b0, req_w = 1'b0;
	logic leg = 1'b0, ext = 1'b0;
	logic [1:0] rate = 2'h2;
	logic [2:0] dly = 3'h3;
	logic [9:0] rnum = 10'h0;
	logic [7:0] fnum = 8'h0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] bsel = 4'h0;
	wire ready, cpl_v, cpl_u, rr, wr, ures, tick, rdv;
	wire [31:0] cpl_d, wd_o, rd_d;
	wire [9:0] reg_o;
	wire [7:0] fn_o;
	wire [3:0] be_o;
	int n_errors = 0;
	int tests_run = 0;
	cxp_ext_port cxp_ext_port_inst (.SYS_CLK(clk), .SRST(srst), .FUND_RST(fund),
		.UCLK_RATE_SEL(rate), .LEGACY_SPACE_EN(leg), .EXTENDED_SPACE_EN(ext),
		.LINK_REQ_VALID(req_v), .LINK_REQ_WRITE(req_w), .LINK_REG_NUM(rnum),
		.LINK_FUNC_NUM(fnum), .LINK_WR_DATA(wdat), .LINK_BYTE_EN(bsel),
		.LINK_REQ_READY(ready), .LINK_CPL_VALID(cpl_v), .LINK_CPL_FROM_USER(cpl_u),
		.LINK_CPL_DATA(cpl_d), .READ_RECEIVED(rr), .WRITE_RECEIVED(wr),
		.REGISTER_NUMBER(reg_o), .FUNCTION_NUMBER(fn_o), .WRITE_DATA(wd_o),
		.WRITE_BYTE_ENABLE(be_o), .READ_DATA(rd_d), .READ_DATA_VALID(rdv),
		.USER_RESET(ures), .USER_CLK_TICK(tick));
	cxp_user_model cxp_user_model_inst (.clk(clk), .srst(srst), .legacy_en(leg),
		.ext_en(ext), .delay(dly), .rd_rcv(rr), .wr_rcv(wr), .reg_num(reg_o),
		.wr_data(wd_o), .be(be_o), .rd_data(rd_d), .rd_valid(rdv));
	// 200 MHz system clock, which also stands in for the reference clock
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task finish_test;
		$display("Checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function logic [31:0] pat(input logic [9:0] r);
		return {8'h5a, 14'h0, r};
	endfunction
	// Drives on a clock edge, holds the request until taken, then lets that edge's updates land
	task req(input logic w, input logic [9:0] r, input logic [7:0] f, input logic [31:0] d,
		input logic [3:0] b);
		@(posedge clk);
		req_v <= 1'b1;
		req_w <= w;
		rnum <= r;
		fnum <= f;
		wdat <= d;
		bsel <= b;
		do @(posedge clk); while (ready !== 1'b1);
		req_v <= 1'b0;
		#1;
	endtask
	task wr_t(input logic [9:0] r, input logic [7:0] f, input logic [31:0] d,
		input logic [3:0] b);
		req(1'b1, r, f, d, b);
		chk("wr_rcv", 1, wr);
		chk("wr_reg", r, reg_o);
		chk("wr_fn", f, fn_o);
		chk("wr_data", d, wd_o);
		chk("wr_be", b, be_o);
	endtask
	// Read: hold length of read-received, then the completion it produced
	task rd_t(input logic [9:0] r, input logic [7:0] f, input int hi, input logic [31:0] d,
		input logic u);
		int n;
		n = 0;
		req(1'b0, r, f, 32'h0, 4'h0);
		chk("rd_reg", r, reg_o);
		chk("rd_fn", f, fn_o);
		chk("rd_ready", 0, ready);
		while (rr === 1'b1 && n < 20)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("rd_len", hi, n);
		chk("rd_reg_end", r, reg_o);
		chk("cpl_ready", 1, ready);
		chk("cpl_v", 1, cpl_v);
		chk("cpl_u", u, cpl_u);
		chk("cpl_d", d, cpl_d);
	endtask
	task tick_t(input logic [1:0] s, input int e);
		int n;
		n = 0;
		@(posedge clk);
		srst <= 1'b1; // Rate is static in use, so it only changes under reset
		rate <= s;
		@(posedge clk);
		srst <= 1'b0;
		repeat (8) @(posedge clk);
		repeat (64)
		begin
			@(posedge clk);
			#1;
			if (tick === 1'b1)
				n++;
		end
		chk("ticks", e, n);
	endtask
	// Fundamental reset must show before the next clock edge; release takes two edges
	task frst_t;
		@(posedge clk);
		#1 chk("ures_idle", 0, ures);
		@(posedge clk);
		fund <= 1'b1;
		#1 chk("ures_set", 1, ures);
		@(posedge clk);
		fund <= 1'b0;
		@(posedge clk);
		#1 chk("ures_hold", 1, ures);
		@(posedge clk);
		#1 chk("ures_free", 0, ures);
	endtask
	// Watchdog: the sequence needs a few thousand cycles at most
	initial
	begin
		#100000;
		n_errors++;
		finish_test;
	end
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		wr_t(10'h012, 8'h03, 32'h1122_3344, 4'hf);
		wr_t(10'h012, 8'h81, 32'haabb_ccdd, 4'h5);
		wr_t(10'h3ff, 8'hff, 32'hcafe_0001, 4'hf);
		@(posedge clk);
		#1 chk("wr_pulse", 0, wr);
		rd_t(10'h012, 8'h01, 1, 32'h0, 1'b0);
		@(posedge clk) leg <= 1'b1;
		rd_t(10'h012, 8'h02, 5, 32'h11bb_33dd, 1'b1);
		rd_t(10'h010, 8'h04, 5, pat(10'h010), 1'b1);
		dly <= 3'h0;
		rd_t(10'h01f, 8'h05, 2, pat(10'h01f), 1'b1);
		dly <= 3'h3;
		rd_t(10'h100, 8'h06, 1, 32'h0, 1'b0);
		@(posedge clk) leg <= 1'b0;
		ext <= 1'b1;
		rd_t(10'h3ff, 8'h07, 5, 32'hcafe_0001, 1'b1);
		rd_t(10'h100, 8'h08, 5, pat(10'h100), 1'b1);
		rd_t(10'h010, 8'h09, 1, 32'h0, 1'b0);
		@(posedge clk) leg <= 1'b1;
		rd_t(10'h00f, 8'h0a, 1, 32'h0, 1'b0);
		rd_t(10'h020, 8'h0b, 1, 32'h0, 1'b0);
		rd_t(10'h0ff, 8'h0c, 1, 32'h0, 1'b0);
		frst_t;
		wr_t(10'h000, 8'h0d, 32'h0000_0001, 4'h1);
		tick_t(2'h0, 20);
		tick_t(2'h1, 40);
		tick_t(2'h2, 64);
		tick_t(2'h3, 64);
		finish_test;
	end
endmodule
`default_nettype wire
